// ===== hdl/cgac_pkg.sv
package cgac_pkg;
   localparam int unsigned ENC_PULSES_PER_REV = 1280000;
   localparam int          POS_W              = 32;
   localparam int          GEAR_W             = 30;
   localparam int          ANGLE_W            = 9;
   localparam logic [8:0]  ANGLE_FULL_TURN    = 9'h0_168;
   localparam logic [7:0]  DO_FUNC_CAM_WINDOW = 8'h18;
   localparam int          CAP_DEPTH          = 800;
   localparam int          CAP_IDX_W          = 10;
   localparam int          TRIG_RESP_NS       = 1000;
   localparam int          CLK_PERIOD_NS      = 20;
   localparam int          TRIG_RESP_CYC      = TRIG_RESP_NS / CLK_PERIOD_NS;
   localparam int          ADDR_W             = 4;
   localparam logic [3:0]  REG_GEAR_NUM       = 4'h0;
   localparam logic [3:0]  REG_GEAR_DEN       = 4'h1;
   localparam logic [3:0]  REG_WIN_START      = 4'h2;
   localparam logic [3:0]  REG_WIN_END        = 4'h3;
   localparam logic [3:0]  REG_CTRL           = 4'h4;
   localparam logic [3:0]  REG_CAP_SRC        = 4'h5;
   localparam logic [3:0]  REG_CAP_COUNT      = 4'h6;
   localparam logic [3:0]  REG_CAP_READ_IDX   = 4'h7;
   localparam logic [3:0]  REG_CAP_DATA       = 4'h8;
   localparam logic [3:0]  REG_IRQ_STATUS     = 4'h9;
   localparam logic [3:0]  REG_IRQ_ENABLE     = 4'hA;
   localparam logic [3:0]  REG_IRQ_CLEAR      = 4'hB;
   localparam logic [3:0]  REG_SLAVE_POS      = 4'hC;
   localparam logic [3:0]  REG_CAM_ANGLE      = 4'hD;
   localparam int          CTRL_CAM_ENGAGE    = 0;
   localparam int          CTRL_CAP_ARM       = 1;
   localparam int          CTRL_TRIG_POL      = 2;
   localparam int          IRQ_CAPTURED       = 0;
   localparam int          IRQ_CAP_FULL       = 1;
   localparam int          IRQ_WIN_ENTER      = 2;
   localparam int          IRQ_W              = 3;
   localparam logic [1:0]  SRC_MOTOR_ENC      = 2'h0;
   localparam logic [1:0]  SRC_LINEAR_SCALE   = 2'h1;
   localparam logic [1:0]  SRC_PULSE_TRAIN    = 2'h2;
   localparam logic [31:0] GEAR_NUM_RESET     = 32'h0000_0010;
   localparam logic [31:0] GEAR_DEN_RESET     = 32'h0000_000A;
endpackage

// ===== hdl/cgac_gear_if.sv
`timescale 1ns/1ns
interface cgac_gear_if;
   logic                     step;
   logic                     dir_neg;
   logic [cgac_pkg::GEAR_W-1:0] num;
   logic [cgac_pkg::GEAR_W-1:0] den;
   logic                     out_step;
   logic                     out_neg;
   modport owner (output step, output dir_neg, output num, output den,
                  input out_step, input out_neg);
   modport scaler (input step, input dir_neg, input num, input den,
                   output out_step, output out_neg);
endinterface

// ===== hdl/cgac_gear_scaler.sv
`timescale 1ns/1ns
module cgac_gear_scaler
   import cgac_pkg::*;
(
   input  wire logic     clk,
   input  wire logic     rst,
   input  wire logic     ce,
   cgac_gear_if.scaler   gif
);
   typedef struct packed {
      logic signed [GEAR_W+1:0] acc;
      logic                     out_step;
      logic                     out_neg;
   } cgac_gs_type;

   cgac_gs_type q;
   cgac_gs_type d;

   // Fractional accumulator: numerator added per input pulse, one output per denominator
   always_comb begin
      d          = q;
      d.out_step = 1'b0;
      if (gif.step) begin
         d.acc     = q.acc + $signed({2'b00, gif.num});
         d.out_neg = gif.dir_neg;
      end
      if (d.acc >= $signed({2'b00, gif.den}) && gif.den != '0) begin
         d.acc      = d.acc - $signed({2'b00, gif.den});
         d.out_step = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         q <= '0;
      end else if (ce) begin
         q <= d;
      end
   end

   assign gif.out_step = q.out_step & ce;
   assign gif.out_neg  = q.out_neg;
endmodule

// ===== hdl/cgac_top.sv
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ns
// What this block does
// - Scale pulse commands by numerator over denominator
// - Pulses in encoder units, slave in user units
// - Cam angle cycles once per cam revolution; slave position counts geared steps without wrapping
// - Same gearing as other position modes
// - Cam window output selectable by code 0x18
// - Window on only inside range while engaged
// - Window forced off while cam disengaged
// - Start<=end: on from start through end
// - Start>end: window wraps through zero
// - Capture latches one selectable source position
// - Capture stores up to 800 entries
// - Trigger only from dedicated high-speed input
// - Trigger edge handled within 1 us, polarity
module cgac_top
   import cgac_pkg::*;
#(
   parameter int CAP_ENTRIES = CAP_DEPTH,
   parameter int CAM_REV_PULSES = 3600
)
(
   input  wire logic                clk,
   input  wire logic                rst,
   input  wire logic                ce,
   input  wire logic [ADDR_W-1:0]   reg_addr,
   input  wire logic [31:0]         reg_wdata,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   output logic      [31:0]         reg_rdata,
   input  wire logic                pulse_cmd_step,
   input  wire logic                pulse_cmd_neg,
   input  wire logic                cam_step,
   input  wire logic                cam_neg,
   input  wire logic [POS_W-1:0]    motor_enc_pos,
   input  wire logic [POS_W-1:0]    linear_scale_pos,
   input  wire logic [POS_W-1:0]    pulse_train_pos,
   input  wire logic                high_speed_trigger_input,
   input  wire logic [7:0]          do_func_sel,
   output logic                     do_pin,
   output logic                     cam_window_output,
   output logic                     slave_step,
   output logic                     slave_neg,
   output logic                     irq
);
   typedef struct packed {
      logic [GEAR_W-1:0]    gear_ratio_numerator;
      logic [GEAR_W-1:0]    gear_ratio_denominator;
      logic [ANGLE_W-1:0]   window_start_angle;
      logic [ANGLE_W-1:0]   window_end_angle;
      logic                 engage;
      logic                 arm;
      logic                 trig_pol;
      logic [1:0]           capture_source_axis;
      logic [31:0]          cam_pos;
      logic [ANGLE_W-1:0]   cam_angle;
      logic [POS_W-1:0]     slave_pos;
      logic [CAP_IDX_W-1:0] cap_count;
      logic [CAP_IDX_W-1:0] rd_idx;
      logic [1:0]           trig_sync;
      logic                 trig_prev;
      logic                 window;
      logic [IRQ_W-1:0]     irq_status;
      logic [IRQ_W-1:0]     irq_enable;
      logic [31:0]          rdata;
      logic                 do_out;
   } cgac_top_type;

   cgac_top_type q;
   cgac_top_type d;

   logic [POS_W-1:0] cap_mem [0:CAP_DEPTH-1];
   logic [POS_W-1:0] cap_word;
   logic [POS_W-1:0] src_pos;
   logic             trig_edge;
   logic             cap_take;
   logic             in_window;
   logic [40:0]      angle_prod;

   cgac_gear_if gif ();

   // Slave axis gearing fed by the pulse command input only; cam steps are not geared
   assign gif.step    = pulse_cmd_step;
   assign gif.dir_neg = pulse_cmd_neg;
   assign gif.num     = q.gear_ratio_numerator;
   assign gif.den     = q.gear_ratio_denominator;

   cgac_gear_scaler u_scaler (
      .clk (clk),
      .rst (rst),
      .ce  (ce),
      .gif (gif)
   );

   // Source selection for capture
   always_comb begin
      case (q.capture_source_axis)
         SRC_MOTOR_ENC:    src_pos = motor_enc_pos;
         SRC_LINEAR_SCALE: src_pos = linear_scale_pos;
         SRC_PULSE_TRAIN:  src_pos = pulse_train_pos;
         default:          src_pos = motor_enc_pos;
      endcase
   end

   // Edge on the synchronised trigger pin only; no software path
   assign trig_edge = (q.trig_sync[1] != q.trig_prev)
                      && (q.trig_sync[1] == ~q.trig_pol);
   assign cap_take  = trig_edge && q.arm
                      && (q.cap_count < CAP_IDX_W'(CAP_ENTRIES));

   // Window compare, inclusive ends, wrap when start exceeds end
   always_comb begin
      if (q.window_start_angle <= q.window_end_angle) begin
         in_window = (q.cam_angle >= q.window_start_angle)
                     && (q.cam_angle <= q.window_end_angle);
      end else begin
         in_window = (q.cam_angle <= q.window_end_angle)
                     || (q.cam_angle >= q.window_start_angle);
      end
   end


   always_comb begin
      d            = q;
      d.trig_sync  = {q.trig_sync[0], high_speed_trigger_input};
      d.trig_prev  = q.trig_sync[1];
      d.rdata      = '0;

      // Cam position within one revolution drives angle each cycle
      if (cam_step && q.engage) begin
         if (cam_neg) begin
            d.cam_pos = (q.cam_pos == 32'h0000_0000) ? 32'(CAM_REV_PULSES - 1)
                                                    : q.cam_pos - 32'h0000_0001;
         end else begin
            d.cam_pos = (q.cam_pos == 32'(CAM_REV_PULSES - 1)) ? 32'h0000_0000
                                                               : q.cam_pos + 32'h0000_0001;
         end
      end

      // Slave position follows geared steps
      if (gif.out_step) begin
         d.slave_pos = gif.out_neg ? q.slave_pos - 32'h0000_0001
                                   : q.slave_pos + 32'h0000_0001;
      end

      d.window = in_window && q.engage;
      d.do_out = (do_func_sel == DO_FUNC_CAM_WINDOW) && d.window;

      if (cap_take) begin
         d.cap_count = q.cap_count + CAP_IDX_W'(1);
      end

      // Register writes
      if (reg_wr) begin
         case (reg_addr)
            REG_GEAR_NUM:     d.gear_ratio_numerator   = reg_wdata[GEAR_W-1:0];
            REG_GEAR_DEN:     d.gear_ratio_denominator = reg_wdata[GEAR_W-1:0];
            REG_WIN_START:    d.window_start_angle     = reg_wdata[ANGLE_W-1:0];
            REG_WIN_END:      d.window_end_angle       = reg_wdata[ANGLE_W-1:0];
            REG_CTRL: begin
               d.engage   = reg_wdata[CTRL_CAM_ENGAGE];
               d.arm      = reg_wdata[CTRL_CAP_ARM];
               d.trig_pol = reg_wdata[CTRL_TRIG_POL];
               if (reg_wdata[CTRL_CAP_ARM] && !q.arm && !cap_take) begin
                  d.cap_count = '0;
               end
               if (!reg_wdata[CTRL_CAM_ENGAGE]) begin
                  d.cam_pos = '0;
               end
            end
            REG_CAP_SRC: begin
               if (!q.arm) begin
                  d.capture_source_axis = reg_wdata[1:0];
               end
            end
            REG_CAP_READ_IDX: d.rd_idx = reg_wdata[CAP_IDX_W-1:0];
            REG_IRQ_ENABLE:   d.irq_enable = reg_wdata[IRQ_W-1:0];
            REG_IRQ_CLEAR:    d.irq_status = q.irq_status & ~reg_wdata[IRQ_W-1:0];
            default: ;
         endcase
      end

      // Angle from the final cam position of this cycle
      angle_prod  = 41'(d.cam_pos) * 41'(ANGLE_FULL_TURN);
      d.cam_angle = ANGLE_W'(angle_prod / 41'(CAM_REV_PULSES));

      // Events set status after any clear so set wins
      if (cap_take) begin
         d.irq_status[IRQ_CAPTURED] = 1'b1;
      end
      if (cap_take && (q.cap_count == CAP_IDX_W'(CAP_ENTRIES - 1))) begin
         d.irq_status[IRQ_CAP_FULL] = 1'b1;
      end
      if (d.window && !q.window) begin
         d.irq_status[IRQ_WIN_ENTER] = 1'b1;
      end

      // Register reads, data in the next cycle
      if (reg_rd) begin
         case (reg_addr)
            REG_GEAR_NUM:     d.rdata = 32'(q.gear_ratio_numerator);
            REG_GEAR_DEN:     d.rdata = 32'(q.gear_ratio_denominator);
            REG_WIN_START:    d.rdata = 32'(q.window_start_angle);
            REG_WIN_END:      d.rdata = 32'(q.window_end_angle);
            REG_CTRL:         d.rdata = 32'({q.trig_pol, q.arm, q.engage});
            REG_CAP_SRC:      d.rdata = 32'(q.capture_source_axis);
            REG_CAP_COUNT:    d.rdata = 32'(q.cap_count);
            REG_CAP_READ_IDX: d.rdata = 32'(q.rd_idx);
            REG_CAP_DATA:     d.rdata = cap_word;
            REG_IRQ_STATUS:   d.rdata = 32'(q.irq_status);
            REG_IRQ_ENABLE:   d.rdata = 32'(q.irq_enable);
            REG_SLAVE_POS:    d.rdata = q.slave_pos;
            REG_CAM_ANGLE:    d.rdata = 32'(q.cam_angle);
            default:          d.rdata = '0;
         endcase
      end
   end

   assign cap_word = (q.rd_idx < CAP_IDX_W'(CAP_DEPTH)) ? cap_mem[q.rd_idx] : '0;

   always_ff @(posedge clk) begin
      if (ce && cap_take && !rst) begin
         cap_mem[q.cap_count] <= src_pos;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         q                        <= '0;
         q.gear_ratio_numerator   <= GEAR_W'(GEAR_NUM_RESET);
         q.gear_ratio_denominator <= GEAR_W'(GEAR_DEN_RESET);
         q.window_end_angle       <= ANGLE_W'(ANGLE_FULL_TURN);
      end else if (ce) begin
         q <= d;
      end
   end

   assign reg_rdata         = q.rdata;
   assign cam_window_output = q.window;
   assign do_pin            = q.do_out;
   assign slave_step        = gif.out_step;
   assign slave_neg         = gif.out_neg;
   assign irq               = |(q.irq_status & q.irq_enable);
endmodule

// ===== testbench/cgac_checker.sv
`timescale 1ns/1ns
module cgac_checker
   import cgac_pkg::*;
(
   input wire logic              clk,
   input wire logic              rst,
   input wire logic              ce,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [31:0]       reg_wdata,
   input wire logic              reg_wr,
   input wire logic              reg_rd,
   input wire logic [31:0]       reg_rdata,
   input wire logic              pulse_cmd_step,
   input wire logic              cam_step,
   input wire logic              high_speed_trigger_input,
   input wire logic [7:0]        do_func_sel,
   input wire logic              do_pin,
   input wire logic              cam_window_output,
   input wire logic              slave_step,
   input wire logic              irq
);
   localparam int RESP = 50;
   logic [31:0] num_q;
   logic [1:0]  src_q;
   logic [2:0]  en_q;
   logic        eng_q;
   logic        arm_q;
   logic        pol_q;
   // Shadow of the numerator, capture source, irq enable and control settings
   always_ff @(posedge clk) begin
      if (rst) begin
         num_q <= GEAR_NUM_RESET;
         src_q <= SRC_MOTOR_ENC;
         en_q <= 3'h0;
         eng_q <= 1'b0;
         arm_q <= 1'b0;
         pol_q <= 1'b0;
      end else if (reg_wr && ce) begin
         if (reg_addr == REG_GEAR_NUM) num_q <= reg_wdata;
         if (reg_addr == REG_CAP_SRC && !arm_q) src_q <= reg_wdata[1:0];
         if (reg_addr == REG_IRQ_ENABLE) en_q <= reg_wdata[2:0];
         if (reg_addr == REG_CTRL) begin
            eng_q <= reg_wdata[CTRL_CAM_ENGAGE];
            arm_q <= reg_wdata[CTRL_CAP_ARM];
            pol_q <= reg_wdata[CTRL_TRIG_POL];
         end
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
      else $error("read data not zero outside read answer");
   src_back_a: assert property ($past(reg_rd && reg_addr == REG_CAP_SRC)
      |-> reg_rdata[1:0] == src_q) else $error("capture source readback wrong");
   num_back_a: assert property ($past(reg_rd && reg_addr == REG_GEAR_NUM)
      |-> reg_rdata[GEAR_W-1:0] == num_q[GEAR_W-1:0]) else $error("numerator readback wrong");
   win_off_a: assert property (!eng_q [*3] |-> !cam_window_output)
      else $error("window on while disengaged");
   do_route_a: assert property ((do_func_sel == DO_FUNC_CAM_WINDOW) [*2]
      ##0 $stable(cam_window_output) |-> do_pin == cam_window_output)
      else $error("output pin does not follow window");
   slave_cause_a: assert property (slave_step |-> $past(pulse_cmd_step)
      || $past(pulse_cmd_step, 2) || $past(pulse_cmd_step, 3))
      else $error("slave step without command step");
   win_cause_a: assert property ($changed(cam_window_output) |-> $past(cam_step)
      || $past(cam_step, 2) || $past(cam_step, 3) || $past(reg_wr) || $past(reg_wr, 2)
      || $past(reg_wr, 3)) else $error("window changed without cause");
   trig_resp_a: assert property (arm_q && en_q[IRQ_CAPTURED] && !pol_q
      && $rose(high_speed_trigger_input) |-> ##[1:RESP] irq) else $error("trigger too slow");
   irq_mask_a: assert property (en_q == 3'h0 |-> !irq) else $error("irq while masked");
   cover property ($rose(cam_window_output));
   cover property (slave_step);
   cover property ($rose(irq));
endmodule

bind cgac_top cgac_checker i_chk (.clk, .rst, .ce, .reg_addr, .reg_wdata, .reg_wr,
   .reg_rd, .reg_rdata, .pulse_cmd_step, .cam_step, .high_speed_trigger_input,
   .do_func_sel, .do_pin, .cam_window_output, .slave_step, .irq);

// ===== testbench/cgac_enc_model.sv
`timescale 1ns/1ns
module cgac_enc_model
   import cgac_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             step,
   input  wire logic             neg,
   output logic      [POS_W-1:0] motor_pos,
   output logic      [POS_W-1:0] scale_pos,
   output logic      [POS_W-1:0] train_pos
);
   // Train counts raw pulses, encoder and scale move by their own pitch
   always_ff @(posedge clk) begin
      if (rst) begin
         motor_pos <= 32'h0000_1000;
         scale_pos <= 32'h0002_0000;
         train_pos <= 32'h0000_0000;
      end else if (step) begin
         train_pos <= neg ? train_pos - 1 : train_pos + 1;
         motor_pos <= motor_pos + 32'h0000_0010;
         scale_pos <= scale_pos + 32'h0000_0003;
      end
   end
endmodule

// ===== testbench/cgac_top_tb.sv
`timescale 1ns/1ns
module cgac_top_tb;
   import cgac_pkg::*;
   logic        clk = 0;
   logic        rst = 1;
   logic [3:0]  addr = 0;
   logic [31:0] wd = 0;
   logic        wr = 0;
   logic        rd = 0;
   logic        pcs = 0;
   logic        pneg = 0;
   logic        ce = 1;
   logic        cs = 0;
   logic        trig = 0;
   logic [7:0]  dsel = 0;
   logic [31:0] rdat;
   logic [31:0] mp, sp, tp;
   logic        dop, win, sst, sneg, irq;
   logic        exp_w;
   int          errors = 0;
   int          check_count = 0;
   int          slv = 0;
   logic [8:0]  s, e, a;
   always #10 clk = ~clk;
   always @(posedge clk) if (sst === 1'b1) slv++;
   cgac_enc_model i_enc (.clk, .rst, .step(pcs), .neg(pneg), .motor_pos(mp),
      .scale_pos(sp), .train_pos(tp));
   cgac_top #(.CAP_ENTRIES(4), .CAM_REV_PULSES(36)) i_dut (.clk, .rst, .ce,
      .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat),
      .pulse_cmd_step(pcs), .pulse_cmd_neg(pneg), .cam_step(cs), .cam_neg(1'b0),
      .motor_enc_pos(mp), .linear_scale_pos(sp), .pulse_train_pos(tp),
      .high_speed_trigger_input(trig), .do_func_sel(dsel), .do_pin(dop),
      .cam_window_output(win), .slave_step(sst), .slave_neg(sneg), .irq(irq));
   task chk(input string n, input logic [31:0] x, input logic [31:0] g);
      check_count++;
      if (g !== x) begin
         errors++;
         $display("unexpected %s expected %h seen %h", n, x, g);
      end
   endtask
   task w(input logic [3:0] ad, input logic [31:0] d);
      @(posedge clk);
      wr <= 1;
      addr <= ad;
      wd <= d;
      @(posedge clk);
      wr <= 0;
   endtask
   task r(input logic [3:0] ad, input logic [31:0] x, input string n);
      @(posedge clk);
      rd <= 1;
      addr <= ad;
      @(posedge clk);
      rd <= 0;
      #1 chk(n, x, rdat);
   endtask
   task edge_to(input logic v);
      @(posedge clk);
      trig <= v;
      repeat (TRIG_RESP_CYC) @(posedge clk);
   endtask
   task test_done;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #1000000;
      errors++;
      test_done;
   end
   initial begin
      repeat (6) @(posedge clk);
      rst <= 0;
      r(REG_GEAR_NUM, GEAR_NUM_RESET, "num");
      r(REG_GEAR_DEN, GEAR_DEN_RESET, "den");
      w(REG_GEAR_NUM, 32'h0000_0003);
      w(REG_GEAR_DEN, 32'h0000_0004);
      repeat (8) begin
         @(posedge clk);
         pcs <= 1;
         @(posedge clk);
         pcs <= 0;
      end
      repeat (5) @(posedge clk);
      chk("slave steps", 32'h0000_0006, slv);
      r(REG_SLAVE_POS, 32'h0000_0006, "slave pos");
      repeat (4) begin
         @(posedge clk);
         pcs <= 1;
         pneg <= 1;
         @(posedge clk);
         pcs <= 0;
      end
      repeat (5) @(posedge clk);
      pneg <= 0;
      r(REG_SLAVE_POS, 32'h0000_0003, "slave back");
      chk("slave dir", 1, sneg);
      $display("test gear done");
      w(REG_CAP_SRC, {30'h0, SRC_LINEAR_SCALE});
      r(REG_CAP_SRC, {30'h0, SRC_LINEAR_SCALE}, "src");
      w(REG_IRQ_ENABLE, 32'h0000_0003);
      w(REG_CTRL, 32'h0000_0002);
      w(REG_CAP_SRC, {30'h0, SRC_PULSE_TRAIN});
      r(REG_CAP_SRC, {30'h0, SRC_LINEAR_SCALE}, "src held");
      r(REG_CAP_COUNT, 32'h0000_0000, "count idle");
      edge_to(1);
      r(REG_CAP_COUNT, 32'h0000_0001, "count rise");
      w(REG_CAP_READ_IDX, 32'h0000_0000);
      r(REG_CAP_DATA, 32'h0002_0024, "data");
      chk("irq", 1, irq);
      w(REG_CTRL, 32'h0000_0006);
      edge_to(0);
      r(REG_CAP_COUNT, 32'h0000_0002, "count fall");
      repeat (3) begin
         edge_to(1);
         edge_to(0);
      end
      r(REG_CAP_COUNT, 32'h0000_0004, "count full");
      w(REG_IRQ_CLEAR, 32'h0000_0007);
      r(REG_IRQ_STATUS, 32'h0000_0000, "status");
      w(REG_IRQ_ENABLE, 32'h0000_0000);
      $display("test capture done");
      w(REG_CTRL, 32'h0000_0001);
      dsel <= DO_FUNC_CAM_WINDOW;
      for (int p = 0; p < 2; p++) begin
         s = p ? 9'd300 : 9'd30;
         e = p ? 9'd40 : 9'd50;
         w(REG_WIN_START, {23'h0, s});
         w(REG_WIN_END, {23'h0, e});
         for (int k = 1; k <= 36; k++) begin
            @(posedge clk);
            cs <= 1;
            @(posedge clk);
            cs <= 0;
            repeat (3) @(posedge clk);
            a = 9'((k % 36) * 10);
            exp_w = (s <= e) ? (a >= s && a <= e) : (a <= e || a >= s);
            #1 chk("window", exp_w, win);
            chk("do pin", exp_w, dop);
         end
         r(REG_CAM_ANGLE, 32'h0000_0000, "angle");
      end
      @(posedge clk);
      ce <= 0;
      repeat (3) begin
         @(posedge clk);
         cs <= 1;
         @(posedge clk);
         cs <= 0;
      end
      @(posedge clk);
      ce <= 1;
      r(REG_CAM_ANGLE, 32'h0000_0000, "angle frozen");
      r(REG_IRQ_STATUS, 32'h0000_0004, "win enter");
      w(REG_CTRL, 32'h0000_0000);
      repeat (3) @(posedge clk);
      #1 chk("window off", 0, win);
      chk("do pin off", 0, dop);
      $display("test cam done");
      test_done;
   end
endmodule
